// file: pkg/mem_pin_pkg.sv
// constants and types for the memory pin interface
package mem_pin_pkg;
   localparam int ADDR_W = 16;
   localparam int BA_W = 3;
   localparam int CS_N = 4;
   localparam int DATA_W = 16;
   localparam int BYTES = 2;
   localparam int SYS_ADDR_W = 32;
   // system address bits that pick the external bank
   localparam int CS_SEL_LSB = 28;
   localparam int FIFO_DEPTH = 8;
   // request word layout: op, system address, bank address, row/col, wdata, mask
   localparam int OP_W = 3;
   localparam int REQ_W = OP_W + SYS_ADDR_W + BA_W + ADDR_W + DATA_W + BYTES;
   localparam logic [2:0] OP_NOP = 3'h0;
   localparam logic [2:0] OP_ACT = 3'h1;
   localparam logic [2:0] OP_RD = 3'h2;
   localparam logic [2:0] OP_WR = 3'h3;
   localparam logic [2:0] OP_PRE = 3'h4;
   localparam logic [2:0] OP_REF = 3'h5;
   localparam logic [2:0] OP_LMR = 3'h6;
   // command pins {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_DESEL = 4'hf;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_LMR = 4'h0;
   // mode register select on bank address
   localparam logic [2:0] BA_MR = 3'h0;
   localparam logic [2:0] BA_EMR = 3'h1;
   localparam logic [2:0] BA_EMR2 = 3'h2;
   localparam logic [2:0] BA_EMR3 = 3'h3;
   // memory clock divider: half period in system clocks
   localparam int MCLK_HALF = 2;
   localparam logic [1:0] MCLK_HALF_M1 = 2'h1;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_CMD = 4'b0010,
      ST_WDATA = 4'b0100,
      ST_RDATA = 4'b1000
   } seq_state_t;
endpackage

// file: src/mem_fifo.sv
// small parameterised request fifo with valid/ready on both sides
`timescale 1ns/1ps
module mem_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready_o = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   // read data is combinational off the array; the sequencer registers it
   assign out_data_o = mem[rd_ptr];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
         end
         if (push && !pop) begin
            count <= (AW+1)'(count + 1'b1);
         end else if (pop && !push) begin
            count <= (AW+1)'(count - 1'b1);
         end
      end
   end
endmodule

// file: src/mem_clk_gen.sv
// free running memory clock pair derived by division
`timescale 1ns/1ps
module mem_clk_gen #(
   parameter logic [1:0] HALF_M1 = 2'h1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // control
   input wire logic enable_i,
   // clock outputs
   output logic clk_p_o,
   output logic clk_n_o,
   output logic rise_o
);
   logic [1:0] div;
   logic phase;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div <= 2'h0;
         phase <= 1'b0;
      end else if (div == HALF_M1) begin
         div <= 2'h0;
         phase <= ~phase;
      end else begin
         div <= 2'(div + 1'b1);
      end
   end

   // divider keeps running so the pair stays continuous once enabled
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         clk_p_o <= 1'b0;
         clk_n_o <= 1'b0;
      end else begin
         clk_p_o <= enable_i & phase;
         clk_n_o <= enable_i & ~phase;
      end
   end

   assign rise_o = (div == HALF_M1) && !phase;
endmodule

// file: src/ddr2_memory_pin_interface.sv
// pin level interface of the external ddr2 controller
`timescale 1ns/1ps
module ddr2_memory_pin_interface import mem_pin_pkg::*; #(
   parameter int DEPTH = FIFO_DEPTH,
   parameter int SEL_LSB = CS_SEL_LSB
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic NRST_I,
   // configuration bits
   input wire logic MEM_CTRL_DISABLE_I,
   input wire logic [1:0] MEM_CLK_PAIR_EN_I,
   input wire logic MEM_STROBE_DIFF_I,
   input wire logic MEM_CLOCK_ENABLE_I,
   input wire logic MEM_TERMINATION_I,
   // request stream
   input wire logic REQ_VALID_I,
   output logic REQ_READY_O,
   input wire logic [OP_W-1:0] REQ_OP_I,
   input wire logic [SYS_ADDR_W-1:0] REQ_SYS_ADDR_I,
   input wire logic [BA_W-1:0] REQ_BANK_I,
   input wire logic [ADDR_W-1:0] REQ_ROW_COL_I,
   input wire logic [DATA_W-1:0] REQ_WDATA_I,
   input wire logic [BYTES-1:0] REQ_MASK_I,
   // read return
   output logic RD_VALID_O,
   output logic [DATA_W-1:0] RD_DATA_O,
   // command pins
   output logic [CS_N-1:0] MEM_BANK_SELECT_N_O,
   output logic MEM_ROW_STROBE_N_O,
   output logic MEM_COL_STROBE_N_O,
   output logic MEM_WRITE_STROBE_N_O,
   output logic [CS_N+2:0] MEM_CMD_OE_O,
   output logic [BA_W-1:0] MEM_BANK_ADDR_O,
   output logic [ADDR_W-1:0] MEM_ROW_COL_ADDR_O,
   output logic MEM_ADDR_OE_O,
   output logic MEM_CLOCK_ENABLE_O,
   output logic MEM_TERMINATION_ENABLE_O,
   output logic MEM_CTRL_OE_O,
   // memory clocks
   output logic [1:0] MEM_DIFF_CLOCK_P_O,
   output logic [1:0] MEM_DIFF_CLOCK_N_O,
   output logic [1:0] MEM_DIFF_CLOCK_OE_O,
   // byte masks
   output logic [BYTES-1:0] MEM_BYTE_MASK_O,
   output logic MEM_BYTE_MASK_OE_O,
   // data bus
   input wire logic [DATA_W-1:0] MEM_DATA_BUS_I,
   output logic [DATA_W-1:0] MEM_DATA_BUS_O,
   output logic [DATA_W-1:0] MEM_DATA_BUS_OE_O,
   // data strobes
   input wire logic [BYTES-1:0] MEM_DATA_STROBE_I,
   output logic [BYTES-1:0] MEM_DATA_STROBE_P_O,
   output logic [BYTES-1:0] MEM_DATA_STROBE_N_O,
   output logic [BYTES-1:0] MEM_DATA_STROBE_P_OE_O,
   output logic [BYTES-1:0] MEM_DATA_STROBE_N_OE_O
);
   logic [REQ_W-1:0] fifo_in;
   logic [REQ_W-1:0] fifo_out;
   logic fifo_valid;
   logic fifo_pop;
   logic [REQ_W-1:0] cur;
   logic [OP_W-1:0] cur_op;
   logic [SYS_ADDR_W-1:0] cur_sys;
   logic [BA_W-1:0] cur_ba;
   logic [ADDR_W-1:0] cur_rc;
   logic [DATA_W-1:0] cur_wd;
   logic [BYTES-1:0] cur_dm;
   seq_state_t state;
   seq_state_t next_state;
   logic out_live;
   logic mclk_rise;
   logic clk0_p;
   logic clk0_n;
   logic [1:0] clk_en_meta;
   logic [1:0] clk_en_sync;
   logic dis_meta;
   logic dis_sync;
   logic diff_meta;
   logic diff_sync;
   logic cke_meta;
   logic cke_sync;
   logic odt_meta;
   logic odt_sync;
   logic [DATA_W-1:0] dq_meta;
   logic [DATA_W-1:0] dq_sync;
   logic [BYTES-1:0] dqs_meta;
   logic [BYTES-1:0] dqs_sync;
   logic [BYTES-1:0] dqs_prev;
   logic dq_drive;
   logic strobe_level;
   logic [3:0] cmd_bits;

   // decode the system address into one active-low bank select
   function automatic logic [CS_N-1:0] bank_decode(input logic [SYS_ADDR_W-1:0] a);
      logic [CS_N-1:0] sel;
      sel = {CS_N{1'b1}};
      sel[a[SEL_LSB +: 2]] = 1'b0;
      return sel;
   endfunction

   // ddr2 truth table {cs_n, ras_n, cas_n, we_n} with cs_n low
   function automatic logic [3:0] cmd_encode(input logic [OP_W-1:0] op);
      logic [3:0] c;
      unique case (op)
         OP_ACT: c = CMD_ACT;
         OP_RD: c = CMD_RD;
         OP_WR: c = CMD_WR;
         OP_PRE: c = CMD_PRE;
         OP_REF: c = CMD_REF;
         OP_LMR: c = CMD_LMR;
         default: c = CMD_NOP;
      endcase
      return c;
   endfunction

   // static controls come from other domains, two flops each
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         clk_en_meta <= 2'h0;
         clk_en_sync <= 2'h0;
         dis_meta <= 1'b1;
         dis_sync <= 1'b1;
         diff_meta <= 1'b0;
         diff_sync <= 1'b0;
         cke_meta <= 1'b0;
         cke_sync <= 1'b0;
         odt_meta <= 1'b0;
         odt_sync <= 1'b0;
      end else begin
         clk_en_meta <= MEM_CLK_PAIR_EN_I;
         clk_en_sync <= clk_en_meta;
         dis_meta <= MEM_CTRL_DISABLE_I;
         dis_sync <= dis_meta;
         diff_meta <= MEM_STROBE_DIFF_I;
         diff_sync <= diff_meta;
         cke_meta <= MEM_CLOCK_ENABLE_I;
         cke_sync <= cke_meta;
         odt_meta <= MEM_TERMINATION_I;
         odt_sync <= odt_meta;
      end
   end

   // read side pins, sampled before use
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         dq_meta <= '0;
         dq_sync <= '0;
         dqs_meta <= '0;
         dqs_sync <= '0;
         dqs_prev <= '0;
      end else begin
         dq_meta <= MEM_DATA_BUS_I;
         dq_sync <= dq_meta;
         dqs_meta <= MEM_DATA_STROBE_I;
         dqs_sync <= dqs_meta;
         dqs_prev <= dqs_sync;
      end
   end

   // outputs leave high-z on the third clock after reset unless disabled
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         out_live <= 1'b0;
      end else begin
         out_live <= ~dis_sync;
      end
   end

   assign fifo_in = {REQ_OP_I, REQ_SYS_ADDR_I, REQ_BANK_I, REQ_ROW_COL_I,
                     REQ_WDATA_I, REQ_MASK_I};

   mem_fifo #(
      .WIDTH(REQ_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .in_valid_i(REQ_VALID_I),
      .in_ready_o(REQ_READY_O),
      .in_data_i(fifo_in),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_out)
   );

   mem_clk_gen #(
      .HALF_M1(MCLK_HALF_M1)
   ) u_clk (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .enable_i(out_live),
      .clk_p_o(clk0_p),
      .clk_n_o(clk0_n),
      .rise_o(mclk_rise)
   );

   // commands issue only on a memory clock rise, and never while disabled
   assign fifo_pop = (state == ST_IDLE) && fifo_valid && mclk_rise && out_live;
   assign {cur_op, cur_sys, cur_ba, cur_rc, cur_wd, cur_dm} = cur;
   assign cmd_bits = cmd_encode(cur_op);

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (fifo_pop) begin
               next_state = ST_CMD;
            end
         end
         ST_CMD: begin
            if (cur_op == OP_WR) begin
               next_state = ST_WDATA;
            end else if (cur_op == OP_RD) begin
               next_state = ST_RDATA;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_WDATA: begin
            if (mclk_rise) begin
               next_state = ST_IDLE;
            end
         end
         ST_RDATA: begin
            if (dqs_sync != '0 && dqs_prev == '0) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state <= ST_IDLE;
      end else if (!out_live) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         cur <= '0;
      end else if (fifo_pop) begin
         cur <= fifo_out;
      end
   end

   // command and address pins, one memory command per issue cycle
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         MEM_BANK_SELECT_N_O <= {CS_N{1'b1}};
         MEM_ROW_STROBE_N_O <= 1'b1;
         MEM_COL_STROBE_N_O <= 1'b1;
         MEM_WRITE_STROBE_N_O <= 1'b1;
         MEM_BANK_ADDR_O <= '0;
         MEM_ROW_COL_ADDR_O <= '0;
      end else if (state == ST_CMD && cur_op != OP_NOP) begin
         MEM_BANK_SELECT_N_O <= bank_decode(cur_sys) | {CS_N{cmd_bits[3]}};
         {MEM_ROW_STROBE_N_O, MEM_COL_STROBE_N_O, MEM_WRITE_STROBE_N_O} <=
            cmd_bits[2:0];
         MEM_BANK_ADDR_O <= cur_ba;
         MEM_ROW_COL_ADDR_O <= cur_rc;
      end else begin
         // deselect between commands: high selects mask the pins
         MEM_BANK_SELECT_N_O <= {CS_N{1'b1}};
         MEM_ROW_STROBE_N_O <= 1'b1;
         MEM_COL_STROBE_N_O <= 1'b1;
         MEM_WRITE_STROBE_N_O <= 1'b1;
      end
   end

   // clock enable and termination follow their controls, not the commands
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         MEM_CLOCK_ENABLE_O <= 1'b0;
         MEM_TERMINATION_ENABLE_O <= 1'b0;
      end else begin
         MEM_CLOCK_ENABLE_O <= cke_sync;
         MEM_TERMINATION_ENABLE_O <= odt_sync;
      end
   end

   // write data, masks and strobes; byte lane i pairs mask i and strobe i
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         MEM_DATA_BUS_O <= '0;
         MEM_BYTE_MASK_O <= {BYTES{1'b1}};
         dq_drive <= 1'b0;
         strobe_level <= 1'b0;
      end else if (state == ST_WDATA) begin
         MEM_DATA_BUS_O <= cur_wd;
         MEM_BYTE_MASK_O <= cur_dm;
         dq_drive <= 1'b1;
         strobe_level <= clk0_p;
      end else begin
         MEM_BYTE_MASK_O <= {BYTES{1'b1}};
         dq_drive <= 1'b0;
         strobe_level <= 1'b0;
      end
   end

   // read return, taken on a strobe rise from the memory
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         RD_VALID_O <= 1'b0;
         RD_DATA_O <= '0;
      end else begin
         RD_VALID_O <= (state == ST_RDATA) && (dqs_sync != '0) && (dqs_prev == '0);
         if (state == ST_RDATA) begin
            RD_DATA_O <= dq_sync;
         end
      end
   end

   assign MEM_CMD_OE_O = {(CS_N+3){out_live}};
   assign MEM_ADDR_OE_O = out_live;
   assign MEM_CTRL_OE_O = out_live;
   assign MEM_BYTE_MASK_OE_O = out_live;
   assign MEM_DIFF_CLOCK_OE_O = {2{out_live}};
   assign MEM_DIFF_CLOCK_P_O = {clk0_p, clk0_p} & clk_en_sync;
   assign MEM_DIFF_CLOCK_N_O = {clk0_n, clk0_n} & clk_en_sync;
   assign MEM_DATA_BUS_OE_O = {DATA_W{dq_drive & out_live}};
   assign MEM_DATA_STROBE_P_O = {BYTES{strobe_level}};
   assign MEM_DATA_STROBE_N_O = {BYTES{~strobe_level}};
   assign MEM_DATA_STROBE_P_OE_O = {BYTES{dq_drive & out_live}};
   assign MEM_DATA_STROBE_N_OE_O = {BYTES{dq_drive & out_live & diff_sync}};
endmodule

// file: testbench/ddr2_memory_pin_interface_props.sv
// concurrent checks on the ports of the ddr2 pin interface
`timescale 1ns/1ps
module ddr2_pin_props
   import mem_pin_pkg::*;
(
   // clock, reset and configuration
   input wire logic CLK_I,
   input wire logic NRST_I,
   input wire logic MEM_CTRL_DISABLE_I,
   input wire logic [1:0] MEM_CLK_PAIR_EN_I,
   input wire logic MEM_STROBE_DIFF_I,
   input wire logic MEM_TERMINATION_I,
   // pins and their enables
   input wire logic [CS_N-1:0] MEM_BANK_SELECT_N_O,
   input wire logic [CS_N+2:0] MEM_CMD_OE_O,
   input wire logic MEM_ADDR_OE_O,
   input wire logic MEM_CTRL_OE_O,
   input wire logic MEM_TERMINATION_ENABLE_O,
   input wire logic [1:0] MEM_DIFF_CLOCK_P_O,
   input wire logic [1:0] MEM_DIFF_CLOCK_N_O,
   input wire logic [1:0] MEM_DIFF_CLOCK_OE_O,
   input wire logic [BYTES-1:0] MEM_BYTE_MASK_O,
   input wire logic MEM_BYTE_MASK_OE_O,
   input wire logic [DATA_W-1:0] MEM_DATA_BUS_OE_O,
   input wire logic [BYTES-1:0] MEM_DATA_STROBE_P_OE_O,
   input wire logic [BYTES-1:0] MEM_DATA_STROBE_N_OE_O
);
   logic [31:0] oes;
   // every output enable in one word
   assign oes = {MEM_CMD_OE_O, MEM_ADDR_OE_O, MEM_CTRL_OE_O, MEM_BYTE_MASK_OE_O,
      MEM_DIFF_CLOCK_OE_O, MEM_DATA_BUS_OE_O, MEM_DATA_STROBE_P_OE_O, MEM_DATA_STROBE_N_OE_O};
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!NRST_I);
   // reset itself is the cause here, so no disable
   chk_reset_hiz: assert property (disable iff (1'b0) !NRST_I |-> oes == 32'h0)
      else $error("outputs driven during reset");
   chk_cmd_one_cycle: assert property (MEM_CMD_OE_O[0] && MEM_BANK_SELECT_N_O != 4'hf
      |=> MEM_BANK_SELECT_N_O == 4'hf) else $error("command held past one cycle");
   chk_single_select: assert property (MEM_CMD_OE_O[0] |-> $onehot0(~MEM_BANK_SELECT_N_O))
      else $error("more than one bank selected");
   chk_release_idle: assert property ($rose(MEM_CMD_OE_O[0])
      |-> MEM_BANK_SELECT_N_O == 4'hf && MEM_BYTE_MASK_O == 2'h3)
      else $error("selects or masks not inactive when driven");
   chk_disable_hiz: assert property (MEM_CTRL_DISABLE_I [*4]
      |=> oes[31:20] == 12'h0) else $error("outputs driven while disabled");
   chk_mask_idle: assert property (MEM_BYTE_MASK_OE_O && MEM_DATA_BUS_OE_O == 16'h0
      |-> MEM_BYTE_MASK_O == 2'h3) else $error("mask low outside write data");
   chk_strobe_with_data: assert property (MEM_DATA_BUS_OE_O != 16'h0
      |-> MEM_DATA_STROBE_P_OE_O == 2'h3) else $error("write data without strobes");
   chk_single_ended: assert property ((!MEM_STROBE_DIFF_I) [*4]
      |-> MEM_DATA_STROBE_N_OE_O == 2'h0) else $error("complement strobe driven");
   chk_diff_strobe_pair: assert property (MEM_STROBE_DIFF_I [*4]
      |-> MEM_DATA_STROBE_N_OE_O == MEM_DATA_STROBE_P_OE_O) else $error("complement strobe missing");
   chk_odt_follow: assert property ((MEM_CTRL_OE_O && $stable(MEM_TERMINATION_I)) [*4]
      |-> MEM_TERMINATION_ENABLE_O == MEM_TERMINATION_I) else $error("termination not following");
   chk_clock_running: assert property ((MEM_CLK_PAIR_EN_I[0] && MEM_DIFF_CLOCK_OE_O[0]) [*8]
      |-> MEM_DIFF_CLOCK_P_O[0] != $past(MEM_DIFF_CLOCK_P_O[0], 2)
      && MEM_DIFF_CLOCK_N_O[0] == !MEM_DIFF_CLOCK_P_O[0]) else $error("memory clock not running");
endmodule
bind ddr2_memory_pin_interface ddr2_pin_props chk (.*);

// file: testbench/ddr2_mem_model.sv
// behavioural ddr2 memory on the far side of the pins
`timescale 1ns/1ps
module ddr2_mem_model (
   // clock and pacing
   input wire logic clk_i,
   input wire logic slow_i,
   // command and write side
   input wire logic [3:0] cs_n_i,
   input wire logic [2:0] cmd_i,
   input wire logic [15:0] addr_i,
   input wire logic [1:0] mask_i,
   input wire logic [15:0] dq_i,
   input wire logic [15:0] dq_oe_i,
   input wire logic [1:0] dqs_i,
   input wire logic [1:0] dqs_oe_i,
   // resolved wire levels
   output logic [15:0] dq_o,
   output logic [1:0] dqs_o
);
   logic [15:0] mem [256];
   logic [15:0] drv = 16'h0;
   logic [1:0] sdrv = 2'h0;
   logic [7:0] wcol = 8'h0;
   logic [7:0] rcol;
   logic sel;
   initial foreach (mem[i]) mem[i] = 16'h0;
   assign sel = cs_n_i != 4'hf;
   // whichever party enables its driver owns the wire
   assign dq_o = (dq_oe_i & dq_i) | (~dq_oe_i & drv);
   assign dqs_o = (dqs_oe_i & dqs_i) | (~dqs_oe_i & sdrv);
   always @(posedge clk_i) begin
      if (sel && cmd_i == 3'b100)
         wcol <= addr_i[7:0];
      // masks taken with the data, standing in for both strobe edges
      for (int b = 0; b < 2; b++)
         if (dq_oe_i[b*8] && !mask_i[b])
            mem[wcol][b*8+:8] <= dq_i[b*8+:8];
   end
   // one read at a time is enough: the sequencer waits for each answer
   always @(posedge clk_i) begin
      if (sel && cmd_i == 3'b101) begin
         rcol = addr_i[7:0];
         // answer in the background so a command during the release is still seen
         fork
            begin
               repeat (slow_i ? 40 : 3) @(posedge clk_i);
               #3.7;
               drv = mem[rcol];
               sdrv = 2'h3;
               #40;
               sdrv = 2'h0;
               #40;
               // released bus must not keep showing the data
               drv = ~drv;
            end
         join_none
      end
   end
endmodule

// file: testbench/ddr2_memory_pin_interface_test.sv
// self-checking bench for the ddr2 pin interface
`timescale 1ns/1ps
module ddr2_memory_pin_interface_test;
   import mem_pin_pkg::*;
   logic CLK_I, NRST_I, MEM_CTRL_DISABLE_I, MEM_STROBE_DIFF_I, MEM_CLOCK_ENABLE_I, slow;
   logic MEM_TERMINATION_I, REQ_VALID_I, REQ_READY_O, RD_VALID_O, MEM_ROW_STROBE_N_O;
   logic MEM_COL_STROBE_N_O, MEM_WRITE_STROBE_N_O, MEM_ADDR_OE_O, MEM_CLOCK_ENABLE_O;
   logic MEM_TERMINATION_ENABLE_O, MEM_CTRL_OE_O, MEM_BYTE_MASK_OE_O;
   logic [1:0] MEM_CLK_PAIR_EN_I, MEM_DIFF_CLOCK_P_O, MEM_DIFF_CLOCK_N_O, MEM_DIFF_CLOCK_OE_O;
   logic [OP_W-1:0] REQ_OP_I;
   logic [SYS_ADDR_W-1:0] REQ_SYS_ADDR_I;
   logic [BA_W-1:0] REQ_BANK_I, MEM_BANK_ADDR_O;
   logic [ADDR_W-1:0] REQ_ROW_COL_I, MEM_ROW_COL_ADDR_O;
   logic [DATA_W-1:0] REQ_WDATA_I, RD_DATA_O, MEM_DATA_BUS_I, MEM_DATA_BUS_O, MEM_DATA_BUS_OE_O;
   logic [BYTES-1:0] REQ_MASK_I, MEM_BYTE_MASK_O, MEM_DATA_STROBE_I, MEM_DATA_STROBE_P_O;
   logic [BYTES-1:0] MEM_DATA_STROBE_N_O, MEM_DATA_STROBE_P_OE_O, MEM_DATA_STROBE_N_OE_O;
   logic [CS_N-1:0] MEM_BANK_SELECT_N_O;
   logic [CS_N+2:0] MEM_CMD_OE_O;
   logic [25:0] pins;
   logic [31:0] oes;
   logic [25:0] cmd_q[$];
   logic [15:0] rd_q[$];
   logic [15:0] shadow[256];
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   int fill;
   ddr2_memory_pin_interface uut (.*);
   ddr2_mem_model partner (.clk_i(CLK_I), .slow_i(slow), .cs_n_i(MEM_BANK_SELECT_N_O),
      .cmd_i({MEM_ROW_STROBE_N_O, MEM_COL_STROBE_N_O, MEM_WRITE_STROBE_N_O}),
      .addr_i(MEM_ROW_COL_ADDR_O), .mask_i(MEM_BYTE_MASK_O), .dq_i(MEM_DATA_BUS_O),
      .dq_oe_i(MEM_DATA_BUS_OE_O), .dqs_i(MEM_DATA_STROBE_P_O),
      .dqs_oe_i(MEM_DATA_STROBE_P_OE_O), .dq_o(MEM_DATA_BUS_I), .dqs_o(MEM_DATA_STROBE_I));
   assign pins = {MEM_BANK_SELECT_N_O, MEM_ROW_STROBE_N_O, MEM_COL_STROBE_N_O,
      MEM_WRITE_STROBE_N_O, MEM_BANK_ADDR_O, MEM_ROW_COL_ADDR_O};
   assign oes = {MEM_CMD_OE_O, MEM_ADDR_OE_O, MEM_CTRL_OE_O, MEM_BYTE_MASK_OE_O,
      MEM_DIFF_CLOCK_OE_O, MEM_DATA_BUS_OE_O, MEM_DATA_STROBE_P_OE_O, MEM_DATA_STROBE_N_OE_O};
   initial begin
      CLK_I = 1'b0;
      forever #5 CLK_I = ~CLK_I;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (miscompares == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ddr2 truth table of ras, cas, we per request
   function automatic logic [2:0] strobes(input logic [2:0] op);
      case (op)
         OP_ACT: return 3'b011;
         OP_RD: return 3'b101;
         OP_WR: return 3'b100;
         OP_PRE: return 3'b010;
         OP_REF: return 3'b001;
         default: return 3'b000;
      endcase
   endfunction
   task automatic offer(input logic [2:0] op, input logic [1:0] cs, input logic [2:0] ba,
      input logic [7:0] col, input logic [1:0] mask);
      REQ_VALID_I = 1'b1;
      REQ_OP_I = op;
      REQ_SYS_ADDR_I = {2'h0, cs, 28'($urandom)};
      REQ_BANK_I = ba;
      REQ_ROW_COL_I = {8'($urandom), col};
      REQ_WDATA_I = 16'($urandom);
      REQ_MASK_I = mask;
   endtask
   // ready seen at this step holds to the next edge, which takes the request
   task automatic taken;
      cmd_q.push_back({~(4'h1 << REQ_SYS_ADDR_I[29:28]), strobes(REQ_OP_I), REQ_BANK_I,
         REQ_ROW_COL_I});
      for (int b = 0; b < 2; b++)
         if (REQ_OP_I == OP_WR && !REQ_MASK_I[b])
            shadow[REQ_ROW_COL_I[7:0]][b*8+:8] = REQ_WDATA_I[b*8+:8];
      if (REQ_OP_I == OP_RD)
         rd_q.push_back(shadow[REQ_ROW_COL_I[7:0]]);
      @(posedge CLK_I);
      #1;
   endtask
   task automatic send(input logic [2:0] op, input logic [1:0] cs, input logic [2:0] ba,
      input logic [7:0] col, input logic [1:0] mask);
      offer(op, cs, ba, col, mask);
      while (REQ_READY_O !== 1'b1) begin
         @(posedge CLK_I);
         #1;
      end
      taken();
   endtask
   task automatic settle(input int n);
      REQ_VALID_I = 1'b0;
      for (int t = 0; t < 3000 && (rd_q.size() > 0 || cmd_q.size() > 0); t++)
         @(posedge CLK_I);
      check("pending results", 32'(cmd_q.size() + rd_q.size()), 32'h0);
      repeat (n) @(posedge CLK_I);
      #1;
   endtask
   always @(posedge CLK_I) begin
      if (MEM_CMD_OE_O[0] === 1'b1 && MEM_BANK_SELECT_N_O !== 4'hf && cmd_q.size() == 0)
         check("unexpected command", pins, 32'h0);
      else if (MEM_CMD_OE_O[0] === 1'b1 && MEM_BANK_SELECT_N_O !== 4'hf)
         check("command pins", pins, cmd_q.pop_front());
      if (RD_VALID_O === 1'b1)
         check("read data", RD_DATA_O, rd_q.size() ? rd_q.pop_front() : 32'hdead);
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      {MEM_CTRL_DISABLE_I, MEM_STROBE_DIFF_I, MEM_CLOCK_ENABLE_I, MEM_TERMINATION_I} = 4'h0;
      {NRST_I, REQ_VALID_I, slow, MEM_CLK_PAIR_EN_I} = 5'h0;
      {REQ_OP_I, REQ_SYS_ADDR_I, REQ_BANK_I, REQ_ROW_COL_I, REQ_WDATA_I, REQ_MASK_I} = '0;
      void'($urandom(50244));
      foreach (shadow[i]) shadow[i] = 16'h0;
      for (int r = 0; r < 2; r++) begin
         repeat (8) @(posedge CLK_I);
         #1;
         if (r == 1)
            check("drive in reset", oes, 32'h0);
         NRST_I = 1'b1;
         repeat (6) @(posedge CLK_I);
         #1;
         check("drive after reset", oes, {12'hfff, 20'h0});
         check("inactive high", {MEM_BANK_SELECT_N_O, MEM_BYTE_MASK_O}, 32'h3f);
         check("inactive low", {MEM_BANK_ADDR_O, MEM_ROW_COL_ADDR_O, MEM_CLOCK_ENABLE_O,
            MEM_TERMINATION_ENABLE_O, MEM_DIFF_CLOCK_P_O}, 32'h0);
         MEM_CLOCK_ENABLE_I = 1'b1;
         MEM_CLK_PAIR_EN_I = 2'h3;
         repeat (5) @(posedge CLK_I);
         #1;
         check("clock enable", MEM_CLOCK_ENABLE_O, 32'h1);
         for (int c = 0; c < 4; c++) begin
            MEM_STROBE_DIFF_I = c[0];
            MEM_TERMINATION_I = c[1];
            send(OP_ACT, 2'(c), 3'(c + 4 * r), 8'(c), 2'h0);
            send(OP_WR, 2'(c), 3'(c), 8'(c), 2'h0);
            send(OP_RD, 2'(c), 3'(c), 8'(c), 2'h0);
            send(OP_LMR, 2'(c), 3'(c), 8'h0, 2'h0);
            send(2'(c) == 0 ? OP_PRE : OP_REF, 2'(c), 3'h7, 8'h40, 2'h0);
         end
         for (int m = 0; m < 4; m++) begin
            send(OP_WR, 2'h1, 3'h7, 8'h20, 2'(m));
            send(OP_RD, 2'h1, 3'h7, 8'h20, 2'h0);
         end
         // stall the far side so the request fifo fills up
         settle(2);
         slow = 1'b1;
         fill = 0;
         while (REQ_READY_O === 1'b1 && fill < 12) begin
            offer(OP_RD, 2'h2, 3'h0, 8'(fill), 2'h0);
            taken();
            fill++;
         end
         check("fifo refusal", fill, FIFO_DEPTH + 1);
         settle(2);
         slow = 1'b0;
         MEM_CTRL_DISABLE_I = 1'b1;
         repeat (6) @(posedge CLK_I);
         #1;
         check("disabled drive", oes[31:20], 32'h0);
         MEM_CTRL_DISABLE_I = 1'b0;
         MEM_CLK_PAIR_EN_I = 2'h1;
         repeat (8) @(posedge CLK_I);
         #1;
         check("pair off", MEM_DIFF_CLOCK_P_O[1], 32'h0);
         {MEM_CLOCK_ENABLE_I, MEM_TERMINATION_I, MEM_CLK_PAIR_EN_I} = 4'h0;
         settle(6);
         NRST_I = 1'b0;
      end
      complete_run();
   end
endmodule
